/* common/plc_map.vh */
`ifndef PLC_MAP_VH
`define PLC_MAP_VH
`define PLC_LINK_CONTROL_OFS 12'h050
`define PLC_ASPM_LSB 0
`define PLC_ASPM_MSB 1
`define PLC_ASPM_RST 2'h0
`define PLC_ASPM_OFF 2'h0
`define PLC_ASPM_L0S 2'h1
`define PLC_ASPM_L1 2'h2
`define PLC_ASPM_BOTH 2'h3
`define PLC_RSVD_BIT 2
`define PLC_RCB_BIT 3
`define PLC_LINK_DISABLE_BIT 4
`define PLC_RETRAIN_BIT 5
`define PLC_COMMON_CLOCK_CONFIG_BIT 6
`define PLC_DELAY_NS 1000000
`define PLC_CLK_NS 25
`define PLC_CNT_LAST 32'h0000_0001
`define PLC_CNT_STEP 32'h0000_0001
`define PLC_CNT_RST 32'h0000_0000
`define PLC_BIT_RST 1'b0
`define PLC_RDATA_RST 16'h0000
`define PLC_BE_LO 0
`define PLC_HI_LSB 7
`define PLC_REG_W 16
`define PLC_STORED_MASK 16'h0053
`endif

/* rtl/plc_link_control.v */
`timescale 1ns/1ps
`include "plc_map.vh"
module plc_link_control #(
    parameter UPSTREAM = 0,
    parameter DELAY_CYCLES = `PLC_DELAY_NS / `PLC_CLK_NS
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire cfg_wr_i,
    input wire [11:0] cfg_addr_i,
    input wire [15:0] cfg_wdata_i,
    input wire [1:0] cfg_be_i,
    output wire [15:0] cfg_rdata_o,
    input wire eeprom_load_i,
    input wire [1:0] eeprom_aspm_i,
    input wire register_unlock_i,
    input wire ltssm_in_recovery_i,
    input wire ltssm_in_config_i,
    output reg [1:0] aspm_applied_o,
    output wire tx_l0s_enable_o,
    output wire l1_enable_o,
    output wire link_disable_o,
    output reg common_clock_config_o,
    output wire retrain_req_o,
    output wire link_training_set_o
);
    localparam REG_W = `PLC_REG_W;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [31:0] CNT_LOAD = DELAY_CYCLES;
    localparam [15:0] STORED_MASK = `PLC_STORED_MASK;

    reg [1:0] aspm_ff;
    reg [1:0] nxt_aspm;
    reg link_disable_ff;
    reg nxt_link_disable;
    reg common_clock_config_ff;
    reg nxt_common_clock_config;
    reg retrain_pulse_ff;
    reg nxt_retrain_pulse;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg defer_ff;
    reg nxt_defer;
    reg [31:0] delay_cnt_ff;
    reg [31:0] nxt_delay_cnt;
    reg [1:0] nxt_aspm_applied;
    reg nxt_common_clock;
    reg [15:0] rdata_ff;
    wire [15:0] nxt_rdata;
    wire [15:0] reg_image;
    wire wr_lo;
    wire retrain_wr;
    wire retrain_ok;
    wire retrain_go;
    wire ltssm_busy;
    wire delay_done;
    wire apply_now;

    function lo_byte_write;
        input wr;
        input [11:0] addr;
        input [1:0] be;
        begin
            lo_byte_write = wr && (addr == `PLC_LINK_CONTROL_OFS) && be[`PLC_BE_LO];
        end
    endfunction

    function field_bit;
        input [15:0] word;
        input integer pos;
        begin
            field_bit = word[pos];
        end
    endfunction

    assign wr_lo = lo_byte_write(cfg_wr_i, cfg_addr_i, cfg_be_i);
    assign retrain_wr = wr_lo && field_bit(cfg_wdata_i, `PLC_RETRAIN_BIT);
    assign retrain_ok = (UPSTREAM == 0) || register_unlock_i;
    assign retrain_go = retrain_wr && retrain_ok;
    assign ltssm_busy = ltssm_in_recovery_i || ltssm_in_config_i;
    assign delay_done = (state_ff == ST_WAIT) && (delay_cnt_ff == `PLC_CNT_LAST);
    // A retrain into a running training holds the new settings back.
    assign apply_now = !defer_ff && !(retrain_go && ltssm_busy);

    always @* begin
        nxt_aspm = aspm_ff;
        if (eeprom_load_i) begin
            nxt_aspm = eeprom_aspm_i;
        end
        if (wr_lo) begin
            // A config write in the same cycle wins over the load.
            nxt_aspm = cfg_wdata_i[`PLC_ASPM_MSB:`PLC_ASPM_LSB];
        end
    end

    always @* begin
        nxt_link_disable = link_disable_ff;
        nxt_common_clock_config = common_clock_config_ff;
        if (wr_lo) begin
            nxt_link_disable = field_bit(cfg_wdata_i, `PLC_LINK_DISABLE_BIT);
            nxt_common_clock_config = field_bit(cfg_wdata_i, `PLC_COMMON_CLOCK_CONFIG_BIT);
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_delay_cnt = delay_cnt_ff;
        nxt_retrain_pulse = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (retrain_go) begin
                    if (UPSTREAM != 0) begin
                        // Delay lets the write completion reach the root first.
                        nxt_state = ST_WAIT;
                        nxt_delay_cnt = CNT_LOAD;
                    end else begin
                        nxt_retrain_pulse = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (retrain_go) begin
                    nxt_delay_cnt = CNT_LOAD;
                end else if (delay_done) begin
                    nxt_state = ST_IDLE;
                    nxt_retrain_pulse = 1'b1;
                end else begin
                    nxt_delay_cnt = delay_cnt_ff - `PLC_CNT_STEP;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @* begin
        nxt_defer = defer_ff;
        if (retrain_go) begin
            nxt_defer = ltssm_busy;
        end else if (defer_ff && !ltssm_busy) begin
            nxt_defer = 1'b0;
        end
    end

    always @* begin
        nxt_aspm_applied = aspm_applied_o;
        nxt_common_clock = common_clock_config_o;
        if (apply_now) begin
            nxt_aspm_applied = nxt_aspm;
            nxt_common_clock = nxt_common_clock_config;
        end
    end

    assign reg_image[`PLC_ASPM_MSB:`PLC_ASPM_LSB] = nxt_aspm;
    assign reg_image[`PLC_RSVD_BIT] = 1'b0;
    assign reg_image[`PLC_RCB_BIT] = 1'b0;
    assign reg_image[`PLC_LINK_DISABLE_BIT] = nxt_link_disable;
    assign reg_image[`PLC_RETRAIN_BIT] = 1'b0;
    assign reg_image[`PLC_COMMON_CLOCK_CONFIG_BIT] = nxt_common_clock_config;
    assign reg_image[REG_W-1:`PLC_HI_LSB] = {(REG_W - `PLC_HI_LSB){1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi = gi + 1) begin : g_rd
            // Only stored fields can ever show a one.
            assign nxt_rdata[gi] = reg_image[gi] & STORED_MASK[gi];
        end
    endgenerate

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            aspm_ff <= `PLC_ASPM_RST;
            link_disable_ff <= `PLC_BIT_RST;
            common_clock_config_ff <= `PLC_BIT_RST;
        end else if (ce_i) begin
            aspm_ff <= nxt_aspm;
            link_disable_ff <= nxt_link_disable;
            common_clock_config_ff <= nxt_common_clock_config;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            delay_cnt_ff <= `PLC_CNT_RST;
            retrain_pulse_ff <= `PLC_BIT_RST;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            delay_cnt_ff <= nxt_delay_cnt;
            retrain_pulse_ff <= nxt_retrain_pulse;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            defer_ff <= `PLC_BIT_RST;
            aspm_applied_o <= `PLC_ASPM_RST;
            common_clock_config_o <= `PLC_BIT_RST;
        end else if (ce_i) begin
            defer_ff <= nxt_defer;
            aspm_applied_o <= nxt_aspm_applied;
            common_clock_config_o <= nxt_common_clock;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= `PLC_RDATA_RST;
        end else if (ce_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_rdata_o = rdata_ff;
    // Receiver L0s is not gated here.
    assign tx_l0s_enable_o = aspm_applied_o[`PLC_ASPM_LSB];
    assign l1_enable_o = aspm_applied_o[`PLC_ASPM_MSB];
    assign link_disable_o = (UPSTREAM == 0) && link_disable_ff;
    assign retrain_req_o = retrain_pulse_ff;
    // The status flag itself lives in the status register.
    assign link_training_set_o = retrain_pulse_ff;
endmodule // plc_link_control

/* test/plc_link_control_checker.sv */
`timescale 1ns/1ps
module plc_chk #(parameter UPSTREAM = 0) (input wire clk_i, rst_n_i, ce_i, cfg_wr_i, register_unlock_i,
    ltssm_in_recovery_i,
    ltssm_in_config_i, tx_l0s_enable_o, l1_enable_o, link_disable_o, common_clock_config_o, retrain_req_o,
    link_training_set_o, input wire [11:0] cfg_addr_i, input wire [15:0] cfg_wdata_i, cfg_rdata_o,
    input wire [1:0] cfg_be_i, aspm_applied_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire hit = ce_i && cfg_wr_i && cfg_addr_i == 12'h050 && cfg_be_i[0];
    wire busy = ltssm_in_recovery_i || ltssm_in_config_i;
    sequence rt_wr; hit && cfg_wdata_i[5] && !UPSTREAM; endsequence
    zero_a: assert property ((cfg_rdata_o & 16'hffac) == 0);
    dec_a: assert property ({l1_enable_o, tx_l0s_enable_o} == aspm_applied_o);
    req_a: assert property (rt_wr |=> retrain_req_o);
    one_a: assert property (retrain_req_o && ce_i && !(hit && cfg_wdata_i[5]) |=> !retrain_req_o);
    flag_a: assert property (link_training_set_o == retrain_req_o);
    set_a: assert property (hit && !busy && !$past(busy) |=>
        {link_disable_o, common_clock_config_o, aspm_applied_o} ==
        $past({cfg_wdata_i[4] && !UPSTREAM, cfg_wdata_i[6], cfg_wdata_i[1:0]}));
    defer_a: assert property (hit && cfg_wdata_i[5] && busy && (!UPSTREAM || register_unlock_i) |=>
        $stable(aspm_applied_o));
    rst_a: assert property (disable iff (1'b0) !rst_n_i |=> !retrain_req_o && !aspm_applied_o);
endmodule // plc_chk
bind plc_link_control plc_chk #(.UPSTREAM(UPSTREAM)) chk_u (.*);

/* test/plc_link_control_test.sv */
`timescale 1ns/1ps
module plc_link_control_test;
    reg clk_i = 0, rst_n_i = 0, ce_i = 1, cfg_wr_i = 0, eeprom_load_i = 0, register_unlock_i = 0;
    reg [11:0] cfg_addr_i = 12'h050;
    reg [15:0] cfg_wdata_i = 0;
    reg [1:0] cfg_be_i = 2'h3, eeprom_aspm_i = 2'h2;
    wire [15:0] cfg_rdata_o;
    wire [1:0] aspm_applied_o;
    wire ltssm_in_recovery_i, ltssm_in_config_i, tx_l0s_enable_o, l1_enable_o, link_disable_o, common_clock_config_o;
    wire retrain_req_o, link_training_set_o;
    integer n_fail = 0, cmp_count = 0, v;
    plc_link_control #(.DELAY_CYCLES(8)) dut_u (.*);
    plc_ltssm_model lt_u (.*);
    wire [15:0] up_rdata;
    wire [1:0] up_aspm;
    wire up_link_disable, up_req, up_flag;
    plc_link_control #(.UPSTREAM(1), .DELAY_CYCLES(8)) dut_up_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
        .cfg_rdata_o(up_rdata), .eeprom_load_i(eeprom_load_i), .eeprom_aspm_i(eeprom_aspm_i),
        .register_unlock_i(register_unlock_i), .ltssm_in_recovery_i(ltssm_in_recovery_i),
        .ltssm_in_config_i(ltssm_in_config_i), .aspm_applied_o(up_aspm), .tx_l0s_enable_o(), .l1_enable_o(),
        .link_disable_o(up_link_disable), .common_clock_config_o(), .retrain_req_o(up_req), .link_training_set_o(up_flag));
    task chk(input [63:0] nm, input [15:0] e, g);
        begin
            cmp_count++;
            if (g !== e) begin
                n_fail++;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr(input [15:0] d);
        begin
            cfg_wdata_i = d;
            cfg_wr_i = 1;
            @(negedge clk_i) cfg_wr_i = 0;
        end
    endtask
    task t_all;
        begin
            wr(16'hffff);
            chk("rdata", 16'h0053, cfg_rdata_o);
            chk("outs", 8'hfc, {retrain_req_o, link_training_set_o, link_disable_o, common_clock_config_o,
                aspm_applied_o, 2'h0});
        end
    endtask
    task t_defer;
        begin
            @(negedge clk_i) chk("req", 0, retrain_req_o);
            wr(16'h0020);
            chk("held", 3, aspm_applied_o);
            repeat (14) @(negedge clk_i);
            chk("late", 0, {link_disable_o, common_clock_config_o, aspm_applied_o});
        end
    endtask
    task t_aspm;
        begin
            for (v = 0; v < 4; v++) begin
                wr(v[15:0]);
                chk("aspm", {v[1:0], v[1:0]}, {aspm_applied_o, l1_enable_o, tx_l0s_enable_o});
                @(negedge clk_i);
            end
            eeprom_load_i = 1;
            @(negedge clk_i) eeprom_load_i = 0;
            chk("eeprom", 2, aspm_applied_o);
        end
    endtask
    task t_ce;
        begin
            ce_i = 0;
            wr(16'h0013);
            chk("ce_hold", 16'h0002, {link_disable_o, aspm_applied_o});
            ce_i = 1;
            @(negedge clk_i) chk("ce_rd", 16'h0002, cfg_rdata_o);
        end
    endtask
    task t_up;
        begin
            register_unlock_i = 0;
            wr(16'h0030);
            chk("up_rd", 16'h0010, up_rdata);
            chk("up_link_disable", 0, up_link_disable);
            repeat (12) begin
                chk("up_lock", 0, up_req);
                @(negedge clk_i);
            end
            register_unlock_i = 1;
            wr(16'h0020);
            repeat (8) begin
                chk("up_wait", 0, {up_req, up_flag});
                @(negedge clk_i);
            end
            chk("up_req", 1, up_req);
            chk("up_flag", 1, up_flag);
            @(negedge clk_i) chk("up_one", 0, up_req);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        t_all;
        t_defer;
        t_aspm;
        t_ce;
        t_up;
        tally_and_finish;
    end
    initial begin
        #20000 n_fail++;
        tally_and_finish;
    end
endmodule // plc_link_control_test

/* test/plc_ltssm_model.sv */
`timescale 1ns/1ps
module plc_ltssm_model (input wire clk_i, retrain_req_o, output wire ltssm_in_recovery_i, ltssm_in_config_i);
    reg [2:0] st_ff = 3'h0;
    // A short retrain keeps the busy window inside a few cycles.
    always @(posedge clk_i) st_ff <= retrain_req_o ? 3'h5 : st_ff - {2'h0, |st_ff};
    assign ltssm_in_recovery_i = st_ff > 3'h2;
    assign ltssm_in_config_i = st_ff == 3'h1 || st_ff == 3'h2;
endmodule // plc_ltssm_model
